// *** design/fbp_ctrl.sv ***
/*
 host-side controller for the flash block-protection command sets.
 takes one command at a time at the user port and expands it into the
 unlock/command/data bus cycles; plain reads return data on o_rdata, password reads on o_password.
 assumes one fbp_cycle instance and a flash that keeps its own rules.
*/
`timescale 1ns/10ps
module fbp_ctrl
    import fbp_pkg::*;
#(
    parameter int UNLOCK_GAP = fbp_pkg::CYC_UNLOCK_GAP
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire fbp_pkg::fbp_cmd_t i_cmd,
    input wire logic [7:0] i_set_code,
    input wire logic i_byte_mode,
    input wire logic [fbp_pkg::ADDR_W-1:0] i_addr,
    input wire logic [fbp_pkg::DATA_W-1:0] i_wdata,
    input wire logic [63:0] i_password,
    output logic o_ready,
    output logic o_done,
    output logic o_refused,
    output logic [fbp_pkg::DATA_W-1:0] o_rdata,
    output logic [63:0] o_password,
    output logic o_in_pw_set,
    output logic o_in_ext_mode,
    input wire logic [fbp_pkg::DATA_W-1:0] i_dq_in,
    output logic o_ce_n,
    output logic o_we_n,
    output logic o_oe_n,
    output logic [fbp_pkg::ADDR_W-1:0] o_addr,
    output logic [fbp_pkg::DATA_W-1:0] o_dq_out,
    output logic o_dq_oe,
    output logic o_byte_select_line
);
    import fbp_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_WAIT = 2'b10
    } fbp_st_t;

    fbp_st_t state;
    fbp_cmd_t cmd;
    logic [7:0] code;
    logic bmode;
    logic [ADDR_W-1:0] uaddr;
    logic [DATA_W-1:0] udata;
    logic [63:0] pw;
    logic [3:0] step;
    logic [3:0] portion;
    logic [3:0] nsteps;
    logic cy_go, cy_done;
    logic [ADDR_W-1:0] cy_addr;
    logic [DATA_W-1:0] cy_wdata, cy_rdata;
    logic cy_write;
    logic [31:0] gap_cnt;
    logic cy_ce_n, cy_we_n, cy_oe_n;

    // unlock-cycle address for the current bus width
    function automatic logic [ADDR_W-1:0] unlock_addr(input logic b, input logic first);
        if (first)
            return b ? ADDR_U1_B : ADDR_U1_W;
        return b ? ADDR_U2_B : ADDR_U2_W;
    endfunction

    // password portion n at the width of the bus
    function automatic logic [DATA_W-1:0] pw_part(input logic [63:0] p, input logic b,
                                                  input logic [3:0] n);
        if (b)
            return {8'h_00, p[8*n[2:0] +: 8]};
        return p[16*n[1:0] +: 16];
    endfunction

    // bus cycles per command; unlock: 2 + 8 byte + 1 -> 11, 2 + 4 word + 1 -> 7
    always_comb begin
        unique case (cmd)
            FBP_ENTER: nsteps = 4'd3;
            FBP_EXIT: nsteps = 4'd2;
            FBP_EXIT_EXT: nsteps = 4'd4;
            FBP_PROG: nsteps = 4'd2;
            FBP_READ: nsteps = 4'd1; // no command code
            FBP_CLEAR_NV: nsteps = 4'd2;
            FBP_PW_PROG: nsteps = 4'd2;
            FBP_PW_READ: nsteps = 4'd1;
            FBP_PW_UNLOCK: nsteps = bmode ? 4'd11 : 4'd7;
            default: nsteps = 4'd1;
        endcase
    end

    // address/data of the current bus cycle; upper byte and high address
    // are left zero on cycles where the flash ignores them
    always_comb begin
        cy_write = 1'b1;
        cy_addr = ADDR_ZERO;
        cy_wdata = '0;
        unique case (cmd)
            FBP_ENTER, FBP_EXIT_EXT: begin
                if (step == 4'd0) begin
                    cy_addr = unlock_addr(bmode, 1'b1);
                    cy_wdata = {8'h_00, CODE_UNLOCK1};
                end else if (step == 4'd1) begin
                    cy_addr = unlock_addr(bmode, 1'b0);
                    cy_wdata = {8'h_00, CODE_UNLOCK2};
                end else if (step == 4'd2) begin
                    cy_addr = unlock_addr(bmode, 1'b1);
                    cy_wdata = {8'h_00, (cmd == FBP_ENTER) ? code : CODE_EXIT1};
                end else begin
                    cy_wdata = {8'h_00, CODE_EXIT2};
                end
            end
            FBP_EXIT: cy_wdata = {8'h_00, (step == 4'd0) ? CODE_EXIT1 : CODE_EXIT2};
            FBP_PROG: begin
                // second cycle carries block address and 00/01 value
                cy_wdata = (step == 4'd0) ? {8'h_00, CODE_PROGRAM} : udata;
                cy_addr = (step == 4'd0) ? ADDR_ZERO : uaddr;
            end
            FBP_CLEAR_NV: cy_wdata = {8'h_00, (step == 4'd0) ? CODE_CLEAR1 : CODE_CLEAR2};
            FBP_READ: begin
                cy_write = 1'b0;
                cy_addr = uaddr;
            end
            FBP_PW_PROG: begin
                cy_wdata = (step == 4'd0) ? {8'h_00, CODE_PROGRAM}
                                          : pw_part(pw, bmode, portion);
                cy_addr = (step == 4'd0) ? ADDR_ZERO : ADDR_W'(portion);
            end
            FBP_PW_READ: begin
                cy_write = 1'b0;
                cy_addr = ADDR_W'(portion);
            end
            FBP_PW_UNLOCK: begin
                if (step == 4'd0)
                    cy_wdata = {8'h_00, CODE_PWUNLK1};
                else if (step == 4'd1)
                    cy_wdata = {8'h_00, CODE_PWUNLK2};
                else if (step == nsteps - 4'd1)
                    cy_wdata = {8'h_00, CODE_PWUNLK2};
                else begin
                    cy_addr = ADDR_W'(step - 4'd2);
                    cy_wdata = pw_part(pw, bmode, step - 4'd2);
                end
            end
            default: cy_write = 1'b1;
        endcase
    end

    // in byte mode the low address bit leaves on the byte-select line
    logic cy_addr_q0;
    logic [ADDR_W-1:0] pin_addr;
    assign cy_addr_q0 = pin_addr[0];
    assign o_byte_select_line = bmode ? cy_addr_q0 : 1'b0;
    assign o_addr = bmode ? {1'b0, pin_addr[ADDR_W-1:1]} : pin_addr;
    assign o_ce_n = cy_ce_n;
    assign o_we_n = cy_we_n;
    assign o_oe_n = cy_oe_n;

    fbp_cycle i_fbp_cycle (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_go(cy_go),
        .i_write(cy_write),
        .i_addr(cy_addr),
        .i_wdata(cy_wdata),
        .i_dq_in(i_dq_in),
        .o_done(cy_done),
        .o_rdata(cy_rdata),
        .o_ce_n(cy_ce_n),
        .o_we_n(cy_we_n),
        .o_oe_n(cy_oe_n),
        .o_addr(pin_addr),
        .o_dq_out(o_dq_out),
        .o_dq_oe(o_dq_oe)
    );

    logic pw_cmd;
    logic gap_busy;
    assign pw_cmd = (i_cmd == FBP_PW_PROG) || (i_cmd == FBP_PW_READ)
                  || (i_cmd == FBP_PW_UNLOCK);
    assign gap_busy = (gap_cnt != 32'h_0000_0000);
    assign o_ready = (state == ST_IDLE);

    // command sequencer
    always_ff @(posedge i_clk) begin
        o_done <= 1'b0;
        o_refused <= 1'b0;
        cy_go <= 1'b0;
        if (i_rst) begin
            state <= ST_IDLE;
            cmd <= FBP_READ;
            code <= 8'h_00;
            bmode <= 1'b0;
            uaddr <= '0;
            udata <= '0;
            pw <= '1;
            step <= 4'd0;
            portion <= 4'd0;
            o_rdata <= '0;
            o_password <= '1;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (i_req) begin
                        // password commands only inside the 60h set
                        // unlock too soon is held back, never sent
                        // erase-style clear not sent in extended mode
                        if ((pw_cmd && !o_in_pw_set)
                            || (i_cmd == FBP_PW_UNLOCK && gap_busy)
                            || (i_cmd == FBP_CLEAR_NV && o_in_ext_mode)) begin
                            o_refused <= 1'b1;
                        end else begin
                            state <= ST_RUN;
                            cmd <= i_cmd;
                            code <= i_set_code;
                            bmode <= i_byte_mode;
                            uaddr <= i_addr;
                            udata <= i_wdata;
                            pw <= i_password;
                            step <= 4'd0;
                            portion <= 4'd0;
                            cy_go <= 1'b1;
                        end
                    end
                end
                ST_RUN: begin
                    if (cy_done) begin
                        if (cmd == FBP_PW_READ)
                            // collect portions in address order
                            if (bmode)
                                o_password[8*portion[2:0] +: 8] <= cy_rdata[7:0];
                            else
                                o_password[16*portion[1:0] +: 16] <= cy_rdata;
                        if (cmd == FBP_READ)
                            o_rdata <= cy_rdata;
                        if (step == nsteps - 4'd1) begin
                            step <= 4'd0;
                            // repeat whole sequence per portion
                            if ((cmd == FBP_PW_PROG || cmd == FBP_PW_READ)
                                && portion != (bmode ? 4'(PW_BYTES - 1) : 4'(PW_WORDS - 1))) begin
                                portion <= portion + 4'd1;
                                cy_go <= 1'b1;
                            end else begin
                                state <= ST_WAIT;
                            end
                        end else begin
                            step <= step + 4'd1;
                            cy_go <= 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    state <= ST_IDLE;
                    o_done <= 1'b1;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // spacing timer between unlock attempts, also covers unlock time
    always_ff @(posedge i_clk) begin
        if (i_rst)
            gap_cnt <= 32'h_0000_0000;
        else if (state == ST_WAIT && cmd == FBP_PW_UNLOCK)
            gap_cnt <= 32'(UNLOCK_GAP);
        else if (gap_busy)
            gap_cnt <= gap_cnt - 32'h_0000_0001;
    end

    // mode tracking: entry sets, exit clears
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_in_pw_set <= 1'b0;
            o_in_ext_mode <= 1'b0;
        end else if (state == ST_WAIT) begin
            if (cmd == FBP_ENTER) begin
                o_in_pw_set <= (code == CODE_PASSWORD);
                o_in_ext_mode <= (code == CODE_EXTBLK);
            end else if (cmd == FBP_EXIT || cmd == FBP_EXIT_EXT) begin
                o_in_pw_set <= 1'b0;
                o_in_ext_mode <= 1'b0;
            end
        end
    end
endmodule

// *** include/fbp_pkg.sv ***
/*
 package of the block-protection command controller: bus cycle codes,
 unlock addresses, command set codes and timing constants.
 assumes a 250 MHz system clock and an asynchronous parallel flash bus.
*/
package fbp_pkg;
    localparam int CLK_MHZ = 250;
    localparam int ADDR_W = 26;
    localparam int DATA_W = 16;
    localparam int CMD_W = 4;

    // unlock addresses, word mode and byte mode
    localparam logic [ADDR_W-1:0] ADDR_U1_W = 26'h000_0555;
    localparam logic [ADDR_W-1:0] ADDR_U2_W = 26'h000_02aa;
    localparam logic [ADDR_W-1:0] ADDR_U1_B = 26'h000_0aaa;
    localparam logic [ADDR_W-1:0] ADDR_U2_B = 26'h000_0555;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 26'h000_0000;

    // data codes
    localparam logic [7:0] CODE_UNLOCK1 = 8'h_aa;
    localparam logic [7:0] CODE_UNLOCK2 = 8'h_55;
    localparam logic [7:0] CODE_LOCKREG = 8'h_40;
    localparam logic [7:0] CODE_PASSWORD = 8'h_60;
    localparam logic [7:0] CODE_NVBITS = 8'h_c0;
    localparam logic [7:0] CODE_NVLOCK = 8'h_50;
    localparam logic [7:0] CODE_VBITS = 8'h_e0;
    localparam logic [7:0] CODE_EXTBLK = 8'h_88;
    localparam logic [7:0] CODE_PROGRAM = 8'h_a0;
    localparam logic [7:0] CODE_EXIT1 = 8'h_90;
    localparam logic [7:0] CODE_EXIT2 = 8'h_00;
    localparam logic [7:0] CODE_CLEAR1 = 8'h_80;
    localparam logic [7:0] CODE_CLEAR2 = 8'h_30;
    localparam logic [7:0] CODE_PWUNLK1 = 8'h_25;
    localparam logic [7:0] CODE_PWUNLK2 = 8'h_03;
    localparam logic [7:0] BIT_PROTECT = 8'h_00;
    localparam logic [7:0] BIT_UNPROTECT = 8'h_01;

    // user commands
    typedef enum logic [CMD_W-1:0] {
        FBP_ENTER = 4'h0, // enter set given by i_set_code
        FBP_EXIT = 4'h1, // two-cycle exit 90/00
        FBP_EXIT_EXT = 4'h2, // four-cycle exit of extended block mode
        FBP_PROG = 4'h3, // A0 then address/data
        FBP_READ = 4'h4, // plain read, no command code
        FBP_CLEAR_NV = 4'h5, // 80/30 clear all nonvolatile bits
        FBP_PW_PROG = 4'h6, // whole 64-bit password program
        FBP_PW_READ = 4'h7, // whole 64-bit password read
        FBP_PW_UNLOCK = 4'h8 // unlock with 64-bit password
    } fbp_cmd_t;

    // bus cycle timing
    localparam int T_WE_LOW_NS = 40;
    localparam int T_WE_HIGH_NS = 20;
    localparam int T_RD_ACC_NS = 100;
    localparam int T_UNLOCK_GAP_US = 6;
    localparam int NS_PER_CYC = 1000 / CLK_MHZ;
    localparam int CYC_WE_LOW = (T_WE_LOW_NS + NS_PER_CYC - 1) / NS_PER_CYC;
    localparam int CYC_WE_HIGH = (T_WE_HIGH_NS + NS_PER_CYC - 1) / NS_PER_CYC;
    localparam int CYC_RD_ACC = (T_RD_ACC_NS + NS_PER_CYC - 1) / NS_PER_CYC;
    localparam int CYC_UNLOCK_GAP = T_UNLOCK_GAP_US * CLK_MHZ;
    localparam int PW_BYTES = 8;
    localparam int PW_WORDS = 4;
endpackage

// *** design/fbp_cycle.sv ***
/*
 one asynchronous bus cycle engine: drives ce/we/oe and address/data of
 the flash for a single write or read, then pulses done.
 assumes the flash data pins are split into in/out/enable by the bench.
*/
`timescale 1ns/10ps
module fbp_cycle
    import fbp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic i_write,
    input wire logic [fbp_pkg::ADDR_W-1:0] i_addr,
    input wire logic [fbp_pkg::DATA_W-1:0] i_wdata,
    input wire logic [fbp_pkg::DATA_W-1:0] i_dq_in,
    output logic o_done,
    output logic [fbp_pkg::DATA_W-1:0] o_rdata,
    output logic o_ce_n,
    output logic o_we_n,
    output logic o_oe_n,
    output logic [fbp_pkg::ADDR_W-1:0] o_addr,
    output logic [fbp_pkg::DATA_W-1:0] o_dq_out,
    output logic o_dq_oe
);
    import fbp_pkg::*;

    typedef enum logic [1:0] {
        CY_IDLE = 2'b00,
        CY_ACT = 2'b01,
        CY_REC = 2'b10
    } fbp_cy_t;

    fbp_cy_t state;
    logic [7:0] cnt;
    logic wr;
    logic [DATA_W-1:0] dq_s1, dq_s2;

    // pin inputs pass two flip-flops before use
    always_ff @(posedge i_clk) begin
        dq_s1 <= i_dq_in;
        dq_s2 <= dq_s1;
    end

    // cycle sequencer; recovery phase keeps we high between writes
    always_ff @(posedge i_clk) begin
        o_done <= 1'b0;
        if (i_rst) begin
            state <= CY_IDLE;
            cnt <= 8'h_00;
            wr <= 1'b0;
            o_ce_n <= 1'b1;
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_addr <= '0;
            o_dq_out <= '0;
            o_dq_oe <= 1'b0;
            o_rdata <= '0;
        end else begin
            unique case (state)
                CY_IDLE: begin
                    if (i_go) begin
                        state <= CY_ACT;
                        wr <= i_write;
                        o_addr <= i_addr;
                        o_dq_out <= i_wdata;
                        o_dq_oe <= i_write;
                        o_ce_n <= 1'b0;
                        o_we_n <= ~i_write;
                        o_oe_n <= i_write;
                        // read waits longer: access plus two sync stages
                        cnt <= i_write ? 8'(CYC_WE_LOW) : 8'(CYC_RD_ACC + 2);
                    end
                end
                CY_ACT: begin
                    if (cnt == 8'h_01) begin
                        state <= CY_REC;
                        cnt <= 8'(CYC_WE_HIGH);
                        o_we_n <= 1'b1;
                        o_oe_n <= 1'b1;
                        o_ce_n <= 1'b1;
                        if (!wr)
                            o_rdata <= dq_s2;
                    end else begin
                        cnt <= cnt - 8'h_01;
                    end
                end
                CY_REC: begin
                    if (cnt == 8'h_01) begin
                        state <= CY_IDLE;
                        o_dq_oe <= 1'b0;
                        o_done <= 1'b1;
                    end else begin
                        cnt <= cnt - 8'h_01;
                    end
                end
                default: state <= CY_IDLE;
            endcase
        end
    end
endmodule

// *** bench/fbp_ctrl_properties.sv ***
/*
 checker of the block-protection command controller, bound to fbp_ctrl.
 assumes it sees only the controller's top ports on the one system clock.
*/
`timescale 1ns/10ps
module fbp_ctrl_properties
    import fbp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire fbp_pkg::fbp_cmd_t i_cmd,
    input wire logic [7:0] i_set_code,
    input wire logic o_ready,
    input wire logic o_done,
    input wire logic o_refused,
    input wire logic o_in_pw_set,
    input wire logic o_in_ext_mode,
    input wire logic o_ce_n,
    input wire logic o_we_n,
    input wire logic o_oe_n,
    input wire logic o_dq_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // a request is taken only on an edge where the controller is idle
    wire logic take = o_ready && i_req;

    idle_bus_a: assert property (o_ready |-> o_ce_n && o_we_n && o_oe_n && !o_dq_oe)
        else $error("bus active while ready");
    done_pulse_a: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
    done_excl_a: assert property (!(o_done && o_refused))
        else $error("done and refused together");
    write_width_a: assert property ($fell(o_we_n) |->
        (!o_we_n)[*8] ##1 !o_we_n ##1 !o_we_n ##1 o_we_n)
        else $error("write strobe width wrong");
    read_strobe_a: assert property (!o_oe_n |-> !o_ce_n && o_we_n && !o_dq_oe)
        else $error("read cycle with bad strobes");
    pw_refused_a: assert property (take && !o_in_pw_set &&
        i_cmd inside {FBP_PW_PROG, FBP_PW_READ, FBP_PW_UNLOCK} |=> o_refused)
        else $error("password command outside set accepted");
    ext_enter_a: assert property (take && i_cmd == FBP_ENTER &&
        i_set_code == CODE_EXTBLK |-> ##[1:100] o_in_ext_mode)
        else $error("extended mode not entered");
    ext_clear_a: assert property (take && i_cmd == FBP_CLEAR_NV &&
        o_in_ext_mode |=> o_refused)
        else $error("clear accepted in extended mode");
    ext_exit_a: assert property (take && i_cmd == FBP_EXIT_EXT |->
        ##[1:100] !o_in_ext_mode)
        else $error("extended mode not left");
    pw_exit_a: assert property (take && i_cmd == FBP_EXIT |-> ##[1:60] !o_in_pw_set)
        else $error("password set not left");

    ext_seen_c: cover property (o_in_ext_mode);
    refused_seen_c: cover property (o_refused);
    unlock_done_c: cover property (take && i_cmd == FBP_PW_UNLOCK ##[1:300] o_done);
endmodule

bind fbp_ctrl fbp_ctrl_properties i_fbp_ctrl_properties (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_cmd(i_cmd), .i_set_code(i_set_code),
    .o_ready(o_ready), .o_done(o_done), .o_refused(o_refused), .o_in_pw_set(o_in_pw_set),
    .o_in_ext_mode(o_in_ext_mode), .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n),
    .o_dq_oe(o_dq_oe)
);

// *** bench/fbp_flash_model.sv ***
/*
 behavioural flash device: command sets, password, protection bits, extended block.
 assumes x16 bus; write cycles are captured on the clock while we_n is low.
*/
`timescale 1ns/10ps
module fbp_flash_model
    import fbp_pkg::*;
#(
    parameter real GAP_NS = 6000.0,
    parameter int PW_LOCK_BIT = 2 // lock register position is arbitrary
) (
    input wire logic i_clk,
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic [fbp_pkg::ADDR_W-1:0] i_addr,
    input wire logic [fbp_pkg::DATA_W-1:0] i_dq,
    output logic [fbp_pkg::DATA_W-1:0] o_dq
);
    logic [ADDR_W-1:0] wa;
    logic [DATA_W-1:0] wd, rd, last, lockreg;
    logic [DATA_W-1:0] ext [128];
    logic [63:0] pw, guess;
    logic [7:0] mode;
    logic [1:0] ucnt;
    logic [3:0] ulcnt;
    logic a0, x90, c80, nvlock;
    logic [3:0] nvb, vb;
    realtime last_ul;
    // power-up state; password all ones
    initial begin
        {mode, ucnt, ulcnt, a0, x90, c80} = '0;
        {pw, lockreg, nvb, vb, nvlock} = '1;
        last_ul = -1.0e9;
        foreach (ext[k]) ext[k] = '1;
    end
    // latch address and data while the write strobe is low
    always @(negedge i_clk) if (!i_ce_n && !i_we_n) begin
        wa <= i_addr;
        wd <= i_dq;
    end
    // decode each write cycle at the end of its strobe
    always @(posedge i_we_n) begin
        if (a0) begin
            a0 = 1'b0;
            case (mode)
                CODE_LOCKREG: lockreg = lockreg & wd;
                CODE_PASSWORD: pw[16*wa[1:0] +: 16] = wd;
                CODE_NVBITS: nvb[wa[17:16]] = 1'b0;
                CODE_NVLOCK: nvlock = 1'b0;
                CODE_VBITS: vb[wa[17:16]] = wd[0];
                CODE_EXTBLK: if (lockreg[0]) ext[wa[6:0]] = ext[wa[6:0]] & wd;
                default: ;
            endcase
        end else if (ulcnt != 0) begin
            if (ulcnt == 4'h6) begin
                if (guess == pw && $realtime - last_ul >= GAP_NS) nvlock = 1'b1;
                last_ul = $realtime;
                ulcnt = '0;
            end else begin
                if (ulcnt > 1) guess[16*wa[1:0] +: 16] = wd;
                ulcnt = ulcnt + 4'h1;
            end
        end else case (wd[7:0])
            CODE_UNLOCK1: ucnt = (wa[10:0] == 11'h555) ? 2'h1 : 2'h0;
            CODE_UNLOCK2: ucnt = (ucnt == 1 && wa[10:0] == 11'h2aa) ? 2'h2 : 2'h0;
            CODE_PROGRAM: a0 = (mode != 0);
            CODE_EXIT1: x90 = 1'b1;
            CODE_CLEAR1: c80 = (mode == CODE_NVBITS);
            CODE_CLEAR2: if (c80 && nvlock) nvb = '1;
            CODE_PWUNLK1: ulcnt = {3'h0, mode == CODE_PASSWORD};
            CODE_EXIT2: if (x90) {mode, x90} = '0;
            default: if (ucnt == 2) {mode, ucnt} = {wd[7:0], 2'h0};
        endcase
    end
    // read data by mode; main array holds an address pattern
    always_comb begin
        case (mode)
            CODE_LOCKREG: rd = lockreg;
            CODE_PASSWORD: rd = lockreg[PW_LOCK_BIT] ? pw[16*i_addr[1:0] +: 16] : '0;
            CODE_NVBITS: rd = {15'h0000, nvb[i_addr[17:16]]};
            CODE_NVLOCK: rd = {15'h0000, nvlock};
            CODE_VBITS: rd = {15'h0000, vb[i_addr[17:16]]};
            CODE_EXTBLK: rd = ext[i_addr[6:0]];
            default: rd = i_addr[15:0] ^ 16'ha5a5;
        endcase
    end
    // a released bus must not keep showing the last value
    always @(posedge i_clk) if (!i_ce_n && !i_oe_n) last <= rd;
    assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~last;
endmodule

// *** bench/fbp_ctrl_tb.sv ***
/*
 testbench of the block-protection command controller against the flash model.
 assumes x16 bus and a short unlock gap of 20 clocks.
*/
`timescale 1ns/10ps
module fbp_ctrl_tb;
    import fbp_pkg::*;
    typedef struct {fbp_cmd_t cmd; logic [7:0] code; logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d; logic chk; logic [DATA_W-1:0] exp;} fbp_row_t;
    logic clk = 1'b0, rst, req, ready, done, refused, in_pw, in_ext, ce_n, we_n, oe_n, dq_oe;
    fbp_cmd_t cmd;
    logic bsl;
    logic [7:0] set_code;
    logic [ADDR_W-1:0] addr, bus_addr;
    logic [DATA_W-1:0] wdata, rdata, dq_out, flash_dq;
    logic [63:0] pw, pw_out;
    int num_errors = 0, tests_run = 0;
    wire logic [DATA_W-1:0] dq = dq_oe ? dq_out : flash_dq;
    fbp_row_t rows [28] = '{
        '{FBP_ENTER, CODE_VBITS, '0, '0, 0, '0},
        '{FBP_PROG, '0, 26'h1_0000, 16'h0000, 0, '0},
        '{FBP_READ, '0, 26'h1_0000, '0, 1, 16'h0000},
        '{FBP_PROG, '0, 26'h1_0000, 16'h0001, 0, '0},
        '{FBP_READ, '0, 26'h1_0000, '0, 1, 16'h0001},
        '{FBP_EXIT, '0, '0, '0, 0, '0},
        '{FBP_ENTER, CODE_NVLOCK, '0, '0, 0, '0},
        '{FBP_PROG, '0, '0, 16'h0000, 0, '0},
        '{FBP_READ, '0, '0, '0, 1, 16'h0000},
        '{FBP_EXIT, '0, '0, '0, 0, '0},
        '{FBP_ENTER, CODE_NVBITS, '0, '0, 0, '0},
        '{FBP_PROG, '0, 26'h2_0000, 16'h0000, 0, '0},
        '{FBP_CLEAR_NV, '0, '0, '0, 0, '0},
        '{FBP_READ, '0, 26'h2_0000, '0, 1, 16'h0000},
        '{FBP_EXIT, '0, '0, '0, 0, '0},
        '{FBP_ENTER, CODE_EXTBLK, '0, '0, 0, '0},
        '{FBP_PROG, '0, 26'h5, 16'h00f0, 0, '0},
        '{FBP_READ, '0, 26'h5, '0, 1, 16'h00f0},
        '{FBP_EXIT_EXT, '0, '0, '0, 0, '0},
        '{FBP_ENTER, CODE_LOCKREG, '0, '0, 0, '0},
        '{FBP_PROG, '0, '0, 16'hfffe, 0, '0},
        '{FBP_READ, '0, '0, '0, 1, 16'hfffe},
        '{FBP_EXIT, '0, '0, '0, 0, '0},
        '{FBP_ENTER, CODE_EXTBLK, '0, '0, 0, '0},
        '{FBP_PROG, '0, 26'h5, 16'h0000, 0, '0},
        '{FBP_READ, '0, 26'h5, '0, 1, 16'h00f0},
        '{FBP_EXIT_EXT, '0, '0, '0, 0, '0},
        '{FBP_READ, '0, 26'h5, '0, 1, 16'ha5a0}
    };

    fbp_ctrl #(.UNLOCK_GAP(20)) i_fbp_ctrl (
        .i_clk(clk), .i_rst(rst), .i_req(req), .i_cmd(cmd), .i_set_code(set_code),
        .i_byte_mode(1'b0), .i_addr(addr), .i_wdata(wdata), .i_password(pw),
        .o_ready(ready), .o_done(done), .o_refused(refused), .o_rdata(rdata),
        .o_password(pw_out), .o_in_pw_set(in_pw), .o_in_ext_mode(in_ext), .i_dq_in(dq),
        .o_ce_n(ce_n), .o_we_n(we_n), .o_oe_n(oe_n), .o_addr(bus_addr), .o_dq_out(dq_out),
        .o_dq_oe(dq_oe), .o_byte_select_line(bsl)
    );
    fbp_flash_model #(.GAP_NS(80.0)) i_fbp_flash_model (
        .i_clk(clk), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_addr(bus_addr),
        .i_dq(dq), .o_dq(flash_dq)
    );

    // 250 MHz clock
    always #2 clk = ~clk;

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one command: request at a falling edge, wait for done or refused
    task automatic run(input fbp_cmd_t c, input logic [7:0] code, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic ref_exp);
        int n;
        n = 0;
        @(negedge clk);
        cmd = c;
        set_code = code;
        addr = a;
        wdata = d;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        while (done !== 1'b1 && refused !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(refused, ref_exp);
        check(n < 3000, 1);
    endtask

    task automatic end_of_test;
        $display("errors %0d, checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // watchdog: whole sequence needs well under 200 us
    initial begin
        #200_000;
        num_errors++;
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        req = 1'b0;
        cmd = FBP_READ;
        set_code = 8'h00;
        addr = '0;
        wdata = '0;
        pw = 64'h0123_4567_89ab_cdef;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check(pw_out, '1);
        check({ce_n, we_n, oe_n, dq_oe, ready, bsl}, 6'h3a);
        foreach (rows[k]) begin
            run(rows[k].cmd, rows[k].code, rows[k].a, rows[k].d, 1'b0);
            if (rows[k].chk) check(rdata, rows[k].exp);
        end
        // password sequence, refusals and spacing of unlock attempts
        run(FBP_PW_PROG, '0, '0, '0, 1'b1);
        run(FBP_ENTER, CODE_PASSWORD, '0, '0, 1'b0);
        run(FBP_PW_READ, '0, '0, '0, 1'b0);
        check(pw_out, '1);
        run(FBP_PW_PROG, '0, '0, '0, 1'b0);
        run(FBP_PW_READ, '0, '0, '0, 1'b0);
        check(pw_out, pw);
        run(FBP_PW_UNLOCK, '0, '0, '0, 1'b0);
        run(FBP_PW_UNLOCK, '0, '0, '0, 1'b1);
        run(FBP_EXIT, '0, '0, '0, 1'b0);
        run(FBP_ENTER, CODE_NVLOCK, '0, '0, 1'b0);
        run(FBP_READ, '0, '0, '0, 1'b0);
        check(rdata, 16'h0001);
        run(FBP_EXIT, '0, '0, '0, 1'b0);
        run(FBP_ENTER, CODE_EXTBLK, '0, '0, 1'b0);
        run(FBP_CLEAR_NV, '0, '0, '0, 1'b1);
        run(FBP_EXIT_EXT, '0, '0, '0, 1'b0);
        end_of_test();
    end
endmodule
